// ==== rtl/mic_event_detect.sv ====
// Edge, overflow and port change detection for the interrupt sources.
`timescale 1ns/10ps
module mic_event_detect (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic pin_i,
    input wire logic edge_sel_i,
    input wire logic [7:0] timer_count_i,
    input wire logic [3:0] port_hi_i,
    input wire logic [3:0] port_in_dir_i,
    input wire logic port_access_i,
    output mic_pkg::mic_events_t events_o
);

    logic pin_prev;
    logic [7:0] timer_prev;
    logic [3:0] port_latch;
    logic rise;
    logic fall;
    logic [3:0] mismatch;

    // Only the selected edge counts.
    assign rise = pin_i & ~pin_prev;
    assign fall = ~pin_i & pin_prev;
    // Output pins are left out of the comparison.
    assign mismatch = (port_hi_i ^ port_latch) & port_in_dir_i;

    // History of the pin and the timer.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_prev <= 1'b0;
            timer_prev <= 8'h00;
        end else begin
            pin_prev <= pin_i;
            timer_prev <= timer_count_i;
        end
    end

    // The compare latch reloads only on a port access, so a mismatch persists.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port_latch <= 4'h0;
        end else if (port_access_i) begin
            port_latch <= port_hi_i;
        end
    end

    // Registered event strobes.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            events_o <= '0;
        end else begin
            events_o.pin_edge <= edge_sel_i ? rise : fall;
            events_o.timer_ovf <= (timer_prev == 8'hFF) && (timer_count_i == 8'h00);
            events_o.port_change <= |mismatch;
        end
    end

endmodule : mic_event_detect

// ==== rtl/mic_irq_ctrl.sv ====
// Interrupt controller of a small microcontroller, with an APB register slave.
// Function
// - Flags set regardless of masks and global enable.
// - Global enable bit 7 gates all requests.
// - Enabled flagged source vectors the core.
// - Any reset clears global enable.
// - Return instruction sets global enable again.
// - Entry clears enable, pushes, loads vector.
// - Peripheral flags, masks, group enable gate.
// - External event latency three or four instructions.
// - Pin interrupt on selected edge sets flag.
// - Cleared pin mask suppresses pin interrupt.
// - Pin wakes only if mask set before sleep.
// - After wake, vector only with global enable.
// - Timer overflow sets timer flag, masked.
// - Upper port change sets flag, masked.
// - Only return address saved; software saves context.
// - Pin flag may set across cycle boundary.
// - Interrupt wake with enable loads vector.
`timescale 1ns/10ps
module mic_irq_ctrl #(
    parameter int unsigned N_PERIPH = 8
) (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic [31:0] PRDATA_O,
    output logic PSLVERR_O,
    input wire logic EXTERNAL_IRQ_PIN_I,
    input wire logic [7:0] TIMER_COUNT_I,
    input wire logic [3:0] PORT_B_DATA_I,
    input wire logic [3:0] PORT_B_IN_DIR_I,
    input wire logic PORT_B_ACCESS_I,
    input wire logic [N_PERIPH-1:0] PERIPH_EVT_I,
    input wire logic [12:0] PC_I,
    input wire logic SLEEP_I,
    input wire logic RETURN_FROM_HANDLER_I,
    output logic VECTOR_O,
    output logic [12:0] VECTOR_ADDR_O,
    output logic [12:0] RETURN_ADDR_O,
    output logic WAKE_O,
    output logic IRQ_O
);

    // Bus decode.
    logic setup_phase;
    logic wr_access;
    logic addr_ok;
    logic wr_ctrl;
    logic wr_pflag;
    logic wr_pmask;
    logic wr_option;
    logic wr_evt_status;
    logic wr_evt_mask;

    // Registers.
    logic [7:0] irq_control_reg;
    logic [N_PERIPH-1:0] peripheral_flag_reg;
    logic [N_PERIPH-1:0] peripheral_mask_reg;
    logic [7:0] option_reg;
    logic [mic_pkg::EVT_W-1:0] evt_status;
    logic [mic_pkg::EVT_W-1:0] evt_mask;
    logic [31:0] next_rdata;

    // Core side state.
    mic_pkg::mic_events_t events;
    mic_pkg::mic_core_req_t core_req;
    mic_pkg::mic_state_t state;
    mic_pkg::mic_state_t next_state;
    logic [$clog2(mic_pkg::Q_PER_INSTR)-1:0] qphase;
    logic [$clog2(mic_pkg::LATENCY_CLKS+1)-1:0] lat_count;
    logic sleep_prev;
    logic pin_mask_at_sleep;
    logic in_handler;
    logic global_irq_enable;
    logic periph_req;
    logic src_req;
    logic pending;
    logic wake_cond;
    logic take_vector;
    logic [mic_pkg::EVT_W-1:0] evt_set;

    // Detection of the pin edge, timer overflow and port change.
    mic_event_detect u_detect (
        .clk_i(MCLK_I),
        .rst_b_i(RST_B_I),
        .pin_i(EXTERNAL_IRQ_PIN_I),
        .edge_sel_i(option_reg[mic_pkg::OPT_EDGE]),
        .timer_count_i(TIMER_COUNT_I),
        .port_hi_i(PORT_B_DATA_I),
        .port_in_dir_i(PORT_B_IN_DIR_I),
        .port_access_i(PORT_B_ACCESS_I),
        .events_o(events)
    );

    // No wait states: the slave answers in the first access cycle.
    assign setup_phase = PSEL_I & ~PENABLE_I;
    assign wr_access = PSEL_I & PENABLE_I & PWRITE_I;
    assign PREADY_O = 1'b1;
    assign wr_ctrl = wr_access && (PADDR_I == mic_pkg::ADDR_IRQ_CTRL);
    assign wr_pflag = wr_access && (PADDR_I == mic_pkg::ADDR_PFLAG);
    assign wr_pmask = wr_access && (PADDR_I == mic_pkg::ADDR_PMASK);
    assign wr_option = wr_access && (PADDR_I == mic_pkg::ADDR_OPTION);
    assign wr_evt_status = wr_access && (PADDR_I == mic_pkg::ADDR_EVT_STATUS);
    assign wr_evt_mask = wr_access && (PADDR_I == mic_pkg::ADDR_EVT_MASK);

    // Address check; an unmapped address gives an error and zero data.
    always_comb begin
        if (PADDR_I == mic_pkg::ADDR_IRQ_CTRL) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == mic_pkg::ADDR_PFLAG) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == mic_pkg::ADDR_PMASK) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == mic_pkg::ADDR_OPTION) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == mic_pkg::ADDR_EVT_STATUS) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == mic_pkg::ADDR_EVT_MASK) begin
            addr_ok = 1'b1;
        end else if (PADDR_I == mic_pkg::ADDR_CORE_STATE) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

    // Read multiplexer; narrow registers sit in the low bits, the rest reads zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (PADDR_I == mic_pkg::ADDR_IRQ_CTRL) begin
            next_rdata[7:0] = irq_control_reg;
        end else if (PADDR_I == mic_pkg::ADDR_PFLAG) begin
            next_rdata[N_PERIPH-1:0] = peripheral_flag_reg;
        end else if (PADDR_I == mic_pkg::ADDR_PMASK) begin
            next_rdata[N_PERIPH-1:0] = peripheral_mask_reg;
        end else if (PADDR_I == mic_pkg::ADDR_OPTION) begin
            next_rdata[7:0] = option_reg;
        end else if (PADDR_I == mic_pkg::ADDR_EVT_STATUS) begin
            next_rdata[mic_pkg::EVT_W-1:0] = evt_status;
        end else if (PADDR_I == mic_pkg::ADDR_EVT_MASK) begin
            next_rdata[mic_pkg::EVT_W-1:0] = evt_mask;
        end else if (PADDR_I == mic_pkg::ADDR_CORE_STATE) begin
            next_rdata[mic_pkg::CST_SLEEP] = SLEEP_I;
            next_rdata[mic_pkg::CST_HANDLER] = in_handler;
            next_rdata[mic_pkg::CST_PENDING] = pending;
        end
    end

    // Read data is captured in the setup cycle so it stands in flops during the access cycle.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (setup_phase && !PWRITE_I) begin
            PRDATA_O <= next_rdata;
        end
    end

    assign global_irq_enable = irq_control_reg[mic_pkg::CTL_GLOBAL];

    // Global enable: entry clears it, return sets it, software writes it.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_control_reg[mic_pkg::CTL_GLOBAL] <= mic_pkg::CTRL_RST[mic_pkg::CTL_GLOBAL];
        end else if (take_vector) begin
            irq_control_reg[mic_pkg::CTL_GLOBAL] <= 1'b0;
        end else if (RETURN_FROM_HANDLER_I) begin
            irq_control_reg[mic_pkg::CTL_GLOBAL] <= 1'b1;
        end else if (wr_ctrl) begin
            irq_control_reg[mic_pkg::CTL_GLOBAL] <= PWDATA_I[mic_pkg::CTL_GLOBAL];
        end
    end

    // Group enable and source masks are plain software bits.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_control_reg[6:3] <= mic_pkg::CTRL_RST[6:3];
        end else if (wr_ctrl) begin
            irq_control_reg[6:3] <= PWDATA_I[6:3];
        end
    end

    // Source flags: a write may clear them, but an event in the same cycle wins.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_control_reg[2:0] <= mic_pkg::CTRL_RST[2:0];
        end else begin
            irq_control_reg[mic_pkg::CTL_TMR_FLAG] <= (wr_ctrl ? PWDATA_I[mic_pkg::CTL_TMR_FLAG]
                : irq_control_reg[mic_pkg::CTL_TMR_FLAG]) | events.timer_ovf;
            irq_control_reg[mic_pkg::CTL_PIN_FLAG] <= (wr_ctrl ? PWDATA_I[mic_pkg::CTL_PIN_FLAG]
                : irq_control_reg[mic_pkg::CTL_PIN_FLAG]) | events.pin_edge;
            irq_control_reg[mic_pkg::CTL_PORT_FLAG] <= (wr_ctrl ? PWDATA_I[mic_pkg::CTL_PORT_FLAG]
                : irq_control_reg[mic_pkg::CTL_PORT_FLAG]) | events.port_change;
        end
    end

    // Peripheral flags, one per source; set beats clear.
    genvar gi;
    generate
        for (gi = 0; gi < N_PERIPH; gi++) begin : g_pflag
            always_ff @(posedge MCLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    peripheral_flag_reg[gi] <= mic_pkg::PFLAG_RST[gi];
                end else begin
                    peripheral_flag_reg[gi] <= (wr_pflag ? PWDATA_I[gi] : peripheral_flag_reg[gi])
                        | PERIPH_EVT_I[gi];
                end
            end
        end
    endgenerate

    // Peripheral masks and the option register.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            peripheral_mask_reg <= mic_pkg::PMASK_RST[N_PERIPH-1:0];
            option_reg <= mic_pkg::OPTION_RST;
        end else begin
            if (wr_pmask) begin
                peripheral_mask_reg <= PWDATA_I[N_PERIPH-1:0];
            end
            if (wr_option) begin
                option_reg <= PWDATA_I[7:0];
            end
        end
    end

    // Request gating: own mask, group enable for the peripheral flags only, then global enable.
    assign periph_req = irq_control_reg[mic_pkg::CTL_GROUP]
        & |(peripheral_flag_reg & peripheral_mask_reg);
    assign src_req = (irq_control_reg[mic_pkg::CTL_TMR_FLAG] & irq_control_reg[mic_pkg::CTL_TMR_MASK])
        | (irq_control_reg[mic_pkg::CTL_PIN_FLAG] & irq_control_reg[mic_pkg::CTL_PIN_MASK])
        | (irq_control_reg[mic_pkg::CTL_PORT_FLAG] & irq_control_reg[mic_pkg::CTL_PORT_MASK])
        | periph_req;
    // A flag the handler leaves set re-enters after return, through the alignment and latency count.
    assign pending = global_irq_enable & src_req;

    // The pin mask at sleep entry decides whether the pin may wake the core.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sleep_prev <= 1'b0;
            pin_mask_at_sleep <= 1'b0;
        end else begin
            sleep_prev <= SLEEP_I;
            if (SLEEP_I && !sleep_prev) begin
                pin_mask_at_sleep <= irq_control_reg[mic_pkg::CTL_PIN_MASK];
            end
        end
    end

    // Wake ignores the global enable, which only decides what follows it.
    assign wake_cond = sleep_prev & SLEEP_I & (
        (irq_control_reg[mic_pkg::CTL_PIN_FLAG] & pin_mask_at_sleep & irq_control_reg[mic_pkg::CTL_PIN_MASK])
        | (irq_control_reg[mic_pkg::CTL_TMR_FLAG] & irq_control_reg[mic_pkg::CTL_TMR_MASK])
        | (irq_control_reg[mic_pkg::CTL_PORT_FLAG] & irq_control_reg[mic_pkg::CTL_PORT_MASK])
        | periph_req);

    // Wake pulse; the sequencer takes over once the core leaves sleep.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            WAKE_O <= 1'b0;
        end else begin
            WAKE_O <= wake_cond & ~WAKE_O;
        end
    end

    // Clock phase within the instruction cycle.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            qphase <= '0;
        end else if (qphase == ($clog2(mic_pkg::Q_PER_INSTR))'(mic_pkg::Q_PER_INSTR - 1)) begin
            qphase <= '0;
        end else begin
            qphase <= qphase + 1'b1;
        end
    end

    // Entry sequencer: align to an instruction boundary, then count fixed cycles.
    // The count ignores instruction length, so one and two cycle instructions give equal latency.
    always_comb begin
        next_state = state;
        case (state)
            mic_pkg::ST_IDLE: begin
                if (pending && !SLEEP_I) begin
                    next_state = mic_pkg::ST_ALIGN;
                end
            end
            mic_pkg::ST_ALIGN: begin
                if (!pending) begin
                    next_state = mic_pkg::ST_IDLE;
                end else if (qphase == ($clog2(mic_pkg::Q_PER_INSTR))'(mic_pkg::Q_PER_INSTR - 1)) begin
                    next_state = mic_pkg::ST_COUNT;
                end
            end
            mic_pkg::ST_COUNT: begin
                if (!pending || lat_count == '0) begin
                    next_state = mic_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = mic_pkg::ST_IDLE;
            end
        endcase
    end

    // Vector when the count expires, the request stands and the core is awake.
    assign take_vector = (state == mic_pkg::ST_COUNT) && (lat_count == '0) && pending && !SLEEP_I;

    // State register.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= mic_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Latency counter, loaded on entering the count state.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            lat_count <= '0;
        end else if (state == mic_pkg::ST_ALIGN) begin
            lat_count <= ($clog2(mic_pkg::LATENCY_CLKS + 1))'(mic_pkg::LATENCY_CLKS - 1);
        end else if (state == mic_pkg::ST_COUNT && lat_count != '0) begin
            lat_count <= lat_count - 1'b1;
        end
    end

    // Entry request: only the return address goes to the stack.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            core_req <= '0;
        end else begin
            core_req.vector <= take_vector;
            if (take_vector) begin
                core_req.vector_addr <= mic_pkg::VECTOR_ADDR;
                core_req.return_addr <= PC_I;
            end
        end
    end

    assign VECTOR_O = core_req.vector;
    assign VECTOR_ADDR_O = core_req.vector_addr;
    assign RETURN_ADDR_O = core_req.return_addr;

    // Handler occupancy, shown in the core state register.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            in_handler <= 1'b0;
        end else if (take_vector) begin
            in_handler <= 1'b1;
        end else if (RETURN_FROM_HANDLER_I) begin
            in_handler <= 1'b0;
        end
    end

    // Sticky event status; a written one clears a bit unless a new event sets it.
    assign evt_set = {RETURN_FROM_HANDLER_I, wake_cond & ~WAKE_O, take_vector};

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            evt_status <= mic_pkg::EVT_RST;
            evt_mask <= mic_pkg::EVT_RST;
        end else begin
            evt_status <= (evt_status & ~(wr_evt_status ? PWDATA_I[mic_pkg::EVT_W-1:0]
                : {mic_pkg::EVT_W{1'b0}})) | evt_set;
            if (wr_evt_mask) begin
                evt_mask <= PWDATA_I[mic_pkg::EVT_W-1:0];
            end
        end
    end

    // Level interrupt while any unmasked event bit is set.
    assign IRQ_O = |(evt_status & evt_mask);

endmodule : mic_irq_ctrl

// ==== rtl/mic_pkg.sv ====
// Register map, field positions, timing counts and types of the interrupt controller.
package mic_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PFLAG = 8'h04;
    localparam logic [7:0] ADDR_PMASK = 8'h08;
    localparam logic [7:0] ADDR_OPTION = 8'h0C;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h10;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h14;
    localparam logic [7:0] ADDR_CORE_STATE = 8'h18;

    // Field positions in the interrupt control register.
    localparam int unsigned CTL_GLOBAL = 7;
    localparam int unsigned CTL_GROUP = 6;
    localparam int unsigned CTL_TMR_MASK = 5;
    localparam int unsigned CTL_PIN_MASK = 4;
    localparam int unsigned CTL_PORT_MASK = 3;
    localparam int unsigned CTL_TMR_FLAG = 2;
    localparam int unsigned CTL_PIN_FLAG = 1;
    localparam int unsigned CTL_PORT_FLAG = 0;

    // Field position of the pin edge select in the option register.
    localparam int unsigned OPT_EDGE = 6;

    // Field positions of the sticky event status and its mask.
    localparam int unsigned EVT_VECTOR = 0;
    localparam int unsigned EVT_WAKE = 1;
    localparam int unsigned EVT_RETURN = 2;
    localparam int unsigned EVT_W = 3;

    // Field positions of the read-only core state register.
    localparam int unsigned CST_SLEEP = 0;
    localparam int unsigned CST_HANDLER = 1;
    localparam int unsigned CST_PENDING = 2;

    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PFLAG_RST = 8'h00;
    localparam logic [7:0] PMASK_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'h00;
    localparam logic [2:0] EVT_RST = 3'h0;

    // Program counter width and the fixed handler vector.
    localparam int unsigned PC_W = 13;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;

    // Clock phases per instruction cycle and the instruction cycles of entry latency.
    localparam int unsigned Q_PER_INSTR = 4;
    localparam int unsigned LATENCY_INSTR = 3;
    localparam int unsigned LATENCY_CLKS = LATENCY_INSTR * Q_PER_INSTR;

    // Source events detected in one clock.
    typedef struct packed {
        logic pin_edge;
        logic timer_ovf;
        logic port_change;
    } mic_events_t;

    // Request to the core: load the vector and push the return address.
    typedef struct packed {
        logic vector;
        logic [12:0] vector_addr;
        logic [12:0] return_addr;
    } mic_core_req_t;

    // Entry sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ALIGN,
        ST_COUNT
    } mic_state_t;

endpackage : mic_pkg

// ==== test/mic_core_model.sv ====
// Behavioural processor core that takes entries, returns and sleeps.
`timescale 1ns/10ps
module mic_core_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic vector_i,
    input wire logic [12:0] vector_addr_i,
    input wire logic wake_i,
    input wire logic sleep_req_i,
    input wire logic ret_req_i,
    output logic [12:0] pc_o,
    output logic sleep_o,
    output logic ret_o
);
    logic [12:0] stack;
    // Only the return address is stacked; other context is the handler's own job.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_o <= 13'h0000;
            stack <= 13'h0000;
        end else if (vector_i) begin
            stack <= pc_o;
            pc_o <= vector_addr_i;
        end else if (ret_o) begin
            pc_o <= stack;
        end else if (!sleep_o) begin
            pc_o <= pc_o + 13'h0001;
        end
    end
    // A sleep request toggles sleep, so a run may leave it without a wake.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sleep_o <= 1'b0;
            ret_o <= 1'b0;
        end else begin
            ret_o <= ret_req_i;
            sleep_o <= sleep_req_i ? !sleep_o : sleep_o && !wake_i;
        end
    end
endmodule : mic_core_model

// ==== test/mic_irq_ctrl_asserts.sv ====
// Port-level checks of the interrupt controller.
`timescale 1ns/10ps
module mic_irq_ctrl_asserts (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic [12:0] PC_I,
    input wire logic SLEEP_I,
    input wire logic VECTOR_O,
    input wire logic [12:0] VECTOR_ADDR_O,
    input wire logic [12:0] RETURN_ADDR_O,
    input wire logic WAKE_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_B_I);
    // Entry clears the enable, so entries stay well apart.
    sequence s_entry; VECTOR_O; endsequence
    sequence s_calm; !VECTOR_O [*8]; endsequence
    a_entry_once: assert property (s_entry |=> s_calm) else $error("entry repeated");
    a_entry_target: assert property (VECTOR_O |-> VECTOR_ADDR_O == mic_pkg::VECTOR_ADDR)
        else $error("bad vector");
    a_return_pc: assert property (VECTOR_O |-> RETURN_ADDR_O == $past(PC_I)) else $error("bad return");
    a_addr_hold: assert property (!VECTOR_O |-> $stable(RETURN_ADDR_O) && $stable(VECTOR_ADDR_O))
        else $error("address moved");
    a_awake_entry: assert property (VECTOR_O |-> !$past(SLEEP_I)) else $error("entry asleep");
    a_wake_once: assert property (WAKE_O |=> !WAKE_O) else $error("wake repeated");
    a_wake_asleep: assert property (WAKE_O |-> $past(SLEEP_I)) else $error("wake while awake");
    a_reset_quiet: assert property ($rose(RST_B_I) |-> !VECTOR_O && !WAKE_O && !IRQ_O)
        else $error("busy after reset");
endmodule : mic_irq_ctrl_asserts

// ==== test/testbench.sv ====
// Bench driving the interrupt controller over APB, its sources and a core model.
`timescale 1ns/10ps
module testbench;
    logic mclk, rst_b, psel, penable, pwrite, pin, pacc, sleep_req, ret_req;
    logic pready, pslverr, vec, wake, irq, sleep, ret;
    logic [7:0] paddr, tmr, pevt;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] port;
    logic [12:0] pc, vaddr;
    int fail_count, checks_done, vec_cnt, wake_cnt, n;
    mic_irq_ctrl mic_irq_ctrl_i (.MCLK_I(mclk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PRDATA_O(prdata),
        .PSLVERR_O(pslverr), .EXTERNAL_IRQ_PIN_I(pin), .TIMER_COUNT_I(tmr), .PORT_B_DATA_I(port),
        .PORT_B_IN_DIR_I(4'hF), .PORT_B_ACCESS_I(pacc), .PERIPH_EVT_I(pevt), .PC_I(pc), .SLEEP_I(sleep),
        .RETURN_FROM_HANDLER_I(ret), .VECTOR_O(vec), .VECTOR_ADDR_O(vaddr), .RETURN_ADDR_O(),
        .WAKE_O(wake), .IRQ_O(irq));
    mic_core_model mic_core_model_i (.clk_i(mclk), .rst_b_i(rst_b), .vector_i(vec), .vector_addr_i(vaddr),
        .wake_i(wake), .sleep_req_i(sleep_req), .ret_req_i(ret_req), .pc_o(pc), .sleep_o(sleep), .ret_o(ret));
    // Clock, and counters of entry and wake pulses.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (vec === 1'b1) vec_cnt++;
        if (wake === 1'b1) wake_cnt++;
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask : tick
    // One APB transfer, held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        do tick(1); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        cmp("slverr", {31'h0, a > 8'h18}, {31'h0, pslverr});
        tick(1);
    endtask : apb
    task automatic ctl(input logic [7:0] d);
        apb(1'b1, mic_pkg::ADDR_IRQ_CTRL, {24'h0, d});
    endtask : ctl
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), x, q);
    endtask : rd
    task automatic ent(input int x);
        tick(40);
        cmp("entries", x, vec_cnt);
    endtask : ent
    task automatic sl;
        sleep_req <= 1'b1;
        tick(1);
        sleep_req <= 1'b0;
    endtask : sl
    // Flags set with all masks clear; a lasting mismatch beats a clear.
    task automatic t_flags;
        rd(mic_pkg::ADDR_IRQ_CTRL, 32'h0);
        rd(8'h1C, 32'h0);
        pin <= 1'b1;
        tmr <= 8'hFF;
        port <= 4'h5;
        pevt <= 8'hA5;
        tick(1);
        pin <= 1'b0;
        tmr <= 8'h00;
        pevt <= 8'h00;
        tick(3);
        rd(mic_pkg::ADDR_IRQ_CTRL, 32'h07);
        rd(mic_pkg::ADDR_PFLAG, 32'hA5);
        ctl(8'h00);
        rd(mic_pkg::ADDR_IRQ_CTRL, 32'h01);
        pacc <= 1'b1;
        tick(1);
        pacc <= 1'b0;
        ctl(8'h00);
        rd(mic_pkg::ADDR_IRQ_CTRL, 32'h0);
        apb(1'b1, mic_pkg::ADDR_PFLAG, 32'h0);
    endtask : t_flags
    // A rising pin edge enters in time; the return restores the enable.
    task automatic t_vector;
        apb(1'b1, mic_pkg::ADDR_EVT_MASK, 32'h1);
        apb(1'b1, mic_pkg::ADDR_OPTION, 32'h40);
        ctl(8'h90);
        pin <= 1'b1;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (vec !== 1'b1 && n < 40);
        cmp("latency", 32'h1, {31'h0, n >= 17 && n <= 20});
        cmp("vector", {19'h0, mic_pkg::VECTOR_ADDR}, {19'h0, vaddr});
        cmp("irq", 32'h1, {31'h0, irq});
        rd(mic_pkg::ADDR_IRQ_CTRL, 32'h12);
        ctl(8'h10);
        apb(1'b1, mic_pkg::ADDR_EVT_STATUS, 32'h1);
        cmp("irq", 32'h0, {31'h0, irq});
        ret_req <= 1'b1;
        tick(1);
        ret_req <= 1'b0;
        tick(2);
        rd(mic_pkg::ADDR_IRQ_CTRL, 32'h90);
        rd(mic_pkg::ADDR_EVT_STATUS, 32'h4);
        ent(1);
    endtask : t_vector
    // The pin mask, the group enable and the global enable each hold an entry back.
    task automatic t_gate;
        ctl(8'h80);
        pin <= 1'b0;
        tick(1);
        pin <= 1'b1;
        ent(1);
        ctl(8'h12);
        ent(1);
        ctl(8'h92);
        ent(2);
        apb(1'b1, mic_pkg::ADDR_PMASK, 32'h1);
        ctl(8'h80);
        pevt <= 8'h01;
        tick(1);
        pevt <= 8'h00;
        ent(2);
        ctl(8'hC0);
        ent(3);
        ctl(8'h00);
    endtask : t_gate
    // A pin wake needs its mask before sleep; entry needs the enable.
    task automatic t_sleep;
        pin <= 1'b0;
        sl;
        ctl(8'h10);
        pin <= 1'b1;
        tick(20);
        cmp("wakes", 32'h0, wake_cnt);
        pin <= 1'b0;
        sl;
        ctl(8'h10);
        sl;
        pin <= 1'b1;
        tick(20);
        cmp("wakes", 32'h1, wake_cnt);
        rd(mic_pkg::ADDR_IRQ_CTRL, 32'h12);
        ent(3);
        ctl(8'h90);
        pin <= 1'b0;
        sl;
        pin <= 1'b1;
        ent(4);
        cmp("wakes", 32'h2, wake_cnt);
    endtask : t_sleep
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // Reset for ten clocks, then the scenarios.
    initial begin
        {psel, penable, pwrite, pin, pacc, sleep_req, ret_req, rst_b} = '0;
        {paddr, tmr, pevt, pwdata, port} = '0;
        tick(10);
        rst_b <= 1'b1;
        tick(1);
        t_flags;
        t_vector;
        t_gate;
        t_sleep;
        wrap_up;
    end
    initial begin
        tick(5000);
        fail_count++;
        wrap_up;
    end
endmodule : testbench
bind mic_irq_ctrl mic_irq_ctrl_asserts mic_irq_ctrl_asserts_i (.MCLK_I, .RST_B_I, .PC_I, .SLEEP_I, .VECTOR_O,
    .VECTOR_ADDR_O, .RETURN_ADDR_O, .WAKE_O, .IRQ_O);
